/* inc/pia_regs_map.vh */
`ifndef PIA_REGS_MAP_VH
`define PIA_REGS_MAP_VH
// ************************************************
// Register indices (word index, byte addr = 4x)
// ************************************************
`define PIA_IDX_IDENT_UPPER   3'h2
`define PIA_IDX_IDENT_LOWER   3'h3
`define PIA_IDX_ADVERT        3'h4
`define PIA_IDX_CONTROL       3'h0
// ************************************************
// Field positions
// ************************************************
`define PIA_OUI_LO_MSB        15
`define PIA_OUI_LO_LSB        10
`define PIA_MODEL_MSB         9
`define PIA_MODEL_LSB         4
`define PIA_REV_MSB           3
`define PIA_REV_LSB           0
`define PIA_ABIL_MSB          8
`define PIA_ABIL_LSB          5
`define PIA_RFAULT_BIT        13
`define PIA_RESTART_BIT       9
`define PIA_ADDR_IDX_MSB      4
`define PIA_ADDR_IDX_LSB      2
`define PIA_ADDR_AL_MSB       1
`define PIA_ADDR_AL_LSB       0
`define PIA_OUI_HI_MSB        21
`define PIA_OUI_HI_LSB        6
`define PIA_OUI_SRC_MSB       5
`define PIA_OUI_SRC_LSB       0
`define PIA_HALF_MSB          15
`define PIA_HALF_LSB          0
`define PIA_UPPER_MSB         31
`define PIA_UPPER_LSB         16
`define PIA_LANE0             0
`define PIA_LANE1             1
`define PIA_LANE_HI_MSB       3
`define PIA_LANE_HI_LSB       2
`define PIA_LANE_BITS         8
`define PIA_RESTART_LANE      1
// ************************************************
// Reset and fixed values
// ************************************************
`define PIA_ADVERT_RESET      16'h01E1
`define PIA_ADVERT_WMASK      16'h21E0
`define PIA_SELECTOR          5'h01
`define PIA_ABIL_RESET        4'hF
`define PIA_ADDR_ALIGNED      2'h0
`define PIA_RFAULT_RESET      1'h0
`define PIA_NEXTPAGE_VALUE    1'h0
`define PIA_ZERO_HALF         16'h0000
`define PIA_ZERO_WORD         32'h0000_0000
`endif

/* hw/pia_regs.v */
`timescale 1ns/10ps
`include "pia_regs_map.vh"
// Overview of operation
// RULE1 - Two read-only identity registers form 32 bits
// RULE2 - Org ident split across upper/lower identity registers
// RULE3 - Lower identity bits 9:4 give model number
// RULE4 - Lower identity bits 3:0 give revision
// RULE5 - Advert bits 8:5 are writable ability field
// RULE6 - Advert writes act only after negotiation restart
// RULE7 - Advert resets 0x01E1; ability, fault writable
// RULE8 - Remote fault bit signalled to link partner
// RULE9 - Ability bit 0 advertises 10BASE-T half duplex
// RULE10 - Selector field fixed at 0x01
// RULE11 - Read-only writes ignored, reserved read zero
module pia_regs #(
    parameter [21:0] ORG_UNIQUE_IDENT   = 22'h000001, // Arbitrary value
    parameter [5:0]  MODEL_NUMBER_FIELD = 6'h01,      // Arbitrary value
    parameter [3:0]  REVISION_FIELD     = 4'h1        // Arbitrary value
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Avalon-MM slave
    input  wire [4:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest,
    // Values used by the negotiation engine
    output reg  [3:0]  activeAbility,
    output reg         activeRemoteFault,
    output wire [4:0]  activeSelector,
    output wire        activeNextPage,
    output reg         restartPulse
);

    // ************************************************
    // Declarations
    // ************************************************
    reg         ackDone;
    reg         next_ackDone;
    reg  [15:0] advertReg;
    reg  [15:0] next_advertReg;
    reg  [31:0] next_avsReadData;
    reg         next_restartPulse;
    reg  [3:0]  next_activeAbility;
    reg         next_activeRemoteFault;
    wire [2:0]  regIdx;
    wire        inRange;
    wire        busReq;
    wire        doWrite;
    wire        doRead;
    wire [15:0] wrMask;
    wire        hitAdvert;
    wire        hitControl;
    wire [15:0] identUpper;
    wire [15:0] identLower;
    wire        unusedFields;

    // ************************************************
    // Helper functions
    // ************************************************
    // Bit mask of the low half from byte enables
    function [15:0] laneMask;
        input [3:0] be;
        begin
            laneMask = {{`PIA_LANE_BITS{be[`PIA_LANE1]}},
                        {`PIA_LANE_BITS{be[`PIA_LANE0]}}};
        end
    endfunction

    // Aligned access to one word index; shared by both write decoders
    function isHit;
        input [2:0] idx;
        input       aligned;
        input [2:0] target;
        begin
            isHit = aligned && (idx == target);
        end
    endfunction

    // Keep old bits outside the mask, take new ones inside
    function [15:0] mergeWrite;
        input [15:0] old;
        input [15:0] wdata;
        input [15:0] mask;
        begin
            mergeWrite = (old & ~mask) | (wdata & mask);
        end
    endfunction

    // Read mux; reserved bits and unmapped words give zero
    function [15:0] readWord;
        input [2:0]  idx;
        input [15:0] upper;
        input [15:0] lower;
        input [15:0] adv;
        begin
            case (idx)
                `PIA_IDX_IDENT_UPPER: readWord = upper; // see RULE1
                `PIA_IDX_IDENT_LOWER: readWord = lower; // see RULE1
                `PIA_IDX_ADVERT:      readWord = adv;
                default:              readWord = `PIA_ZERO_HALF; // see RULE11
            endcase
        end
    endfunction

    // ************************************************
    // Address and handshake decode
    // ************************************************
    assign regIdx  = avsAddress[`PIA_ADDR_IDX_MSB:`PIA_ADDR_IDX_LSB];
    // Misaligned byte addresses hit nothing rather than alias
    assign inRange = (avsAddress[`PIA_ADDR_AL_MSB:`PIA_ADDR_AL_LSB]
                      == `PIA_ADDR_ALIGNED);
    assign busReq  = avsRead | avsWrite;
    // A request is taken once, at its first edge; ackDone masks the rest
    assign doWrite = avsWrite & ~ackDone;
    assign doRead  = avsRead & ~ackDone;

    // One wait cycle per access, so read data can come from a flop
    assign avsWaitRequest = busReq & ~ackDone;

    // Only ability and remote fault bits in enabled lanes take writes
    assign wrMask = `PIA_ADVERT_WMASK
                  & laneMask(avsByteEnable); // see RULE11
    assign hitAdvert  = doWrite
                        && isHit(regIdx, inRange, `PIA_IDX_ADVERT);
    // Restart bit lives in byte lane 1 of the control word
    assign hitControl = doWrite
                        && isHit(regIdx, inRange, `PIA_IDX_CONTROL)
                        && avsByteEnable[`PIA_RESTART_LANE];

    // ************************************************
    // Identity words
    // ************************************************
    // Pure wiring from parameters: nothing to write, nothing to reset
    assign identUpper =
        ORG_UNIQUE_IDENT[`PIA_OUI_HI_MSB:`PIA_OUI_HI_LSB]; // see RULE2
    assign identLower = {
        ORG_UNIQUE_IDENT[`PIA_OUI_SRC_MSB:`PIA_OUI_SRC_LSB], // see RULE2
        MODEL_NUMBER_FIELD,                                  // see RULE3
        REVISION_FIELD};                                     // see RULE4

    // ************************************************
    // Read data
    // ************************************************
    // Loaded at the take edge, stands until the next read
    always @* begin
        next_avsReadData = avsReadData;
        if (doRead) begin
            if (inRange) begin
                next_avsReadData = {`PIA_ZERO_HALF,
                    readWord(regIdx, identUpper, identLower,
                             advertReg)}; // see RULE2
            end else begin
                next_avsReadData = `PIA_ZERO_WORD; // see RULE11
            end
        end
    end

    // Flag drops after each answer so back-to-back requests re-arm
    always @* begin
        next_ackDone = busReq & ~ackDone;
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ackDone     <= 1'h0;
            avsReadData <= `PIA_ZERO_WORD;
        end else begin
            ackDone     <= next_ackDone;
            avsReadData <= next_avsReadData;
        end
    end

    // ************************************************
    // Advertisement register
    // ************************************************
    // Read-only bits never leave their reset values
    always @* begin
        next_advertReg = advertReg;
        if (hitAdvert) begin
            next_advertReg = mergeWrite(advertReg, // see RULE5
                avsWriteData[`PIA_HALF_MSB:`PIA_HALF_LSB], wrMask);
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            advertReg <= `PIA_ADVERT_RESET; // see RULE7
        end else begin
            advertReg <= next_advertReg;
        end
    end

    // ************************************************
    // Negotiation restart
    // ************************************************
    // Restart bit is self clearing: it only yields a pulse, so the
    // control word reads back as zero and needs no storage
    always @* begin
        next_restartPulse = hitControl
                            && avsWriteData[`PIA_RESTART_BIT];
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            restartPulse <= 1'h0;
        end else begin
            restartPulse <= next_restartPulse;
        end
    end

    // ************************************************
    // Values handed to the negotiation engine
    // ************************************************
    // Engine sees a new advert only at restart; a write alone is
    // invisible to it, so software may build the word in steps
    always @* begin
        next_activeAbility     = activeAbility;
        next_activeRemoteFault = activeRemoteFault;
        if (restartPulse) begin
            next_activeAbility     =
                advertReg[`PIA_ABIL_MSB:`PIA_ABIL_LSB]; // see RULE6 RULE9
            next_activeRemoteFault =
                advertReg[`PIA_RFAULT_BIT]; // see RULE8
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            activeAbility     <= `PIA_ABIL_RESET;
            activeRemoteFault <= `PIA_RFAULT_RESET;
        end else begin
            activeAbility     <= next_activeAbility;
            activeRemoteFault <= next_activeRemoteFault;
        end
    end

    // Selector and next page are hard wired
    assign activeSelector = `PIA_SELECTOR; // see RULE10
    assign activeNextPage = `PIA_NEXTPAGE_VALUE;

    // Upper data lanes and upper byte enables carry nothing here
    assign unusedFields = ^avsWriteData[`PIA_UPPER_MSB:`PIA_UPPER_LSB]
                        ^ ^avsByteEnable[`PIA_LANE_HI_MSB:`PIA_LANE_HI_LSB];

endmodule // pia_regs

/* test/pia_regs_asserts.sv */
`timescale 1ns/10ps
// ****************
// Bus and engine checks
// ****************
module pia_regs_asserts (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Register bus
    input wire [4:0]  avsAddress,
    input wire        avsRead,
    input wire        avsWrite,
    input wire [31:0] avsWriteData,
    input wire [31:0] avsReadData,
    input wire        avsWaitRequest,
    // Engine side
    input wire [3:0]  activeAbility,
    input wire        activeRemoteFault,
    input wire [4:0]  activeSelector,
    input wire        activeNextPage,
    input wire        restartPulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sel_fixed_a: assert property (activeSelector == 5'h01)
        else $error("selector not fixed");
    next_zero_a: assert property (!activeNextPage)
        else $error("next page set");
    one_wait_a: assert property ($rose(avsRead | avsWrite) |->
        avsWaitRequest ##1 !avsWaitRequest) else $error("wait cycles");
    upper_zero_a: assert property (avsRead && !avsWaitRequest |->
        avsReadData[31:16] == 16'h0000) else $error("upper half set");
    abil_hold_a: assert property ($changed(activeAbility) |->
        $past(restartPulse)) else $error("ability moved early");
    fault_hold_a: assert property ($changed(activeRemoteFault) |->
        $past(restartPulse)) else $error("fault moved early");
    pulse_one_a: assert property (restartPulse |=> !restartPulse)
        else $error("pulse too long");
    pulse_cause_a: assert property ($rose(restartPulse) |->
        $past(avsWrite && avsAddress == 5'h00 && avsWriteData[9], 1) ||
        $past(avsWrite && avsAddress == 5'h00 && avsWriteData[9], 2))
        else $error("pulse without cause");
endmodule // pia_regs_asserts
bind pia_regs pia_regs_asserts chk_u (.*);

/* test/test_pia_regs.sv */
`timescale 1ns/10ps
module test_pia_regs;
    // Ident values arbitrary
    localparam [21:0] ORG = 22'h2AB5C3;
    reg         clk_sys = 0, rst = 1, avsRead = 0, avsWrite = 0;
    reg  [4:0]  avsAddress = 0;
    reg  [31:0] avsWriteData = 0;
    reg  [15:0] rv;
    wire [31:0] avsReadData;
    wire        avsWaitRequest, activeNextPage, restartPulse, activeRemoteFault;
    wire [3:0]  activeAbility;
    wire [4:0]  activeSelector;
    integer     err_count = 0, tests_run = 0, cyc = 0;
    pia_regs #(.ORG_UNIQUE_IDENT(ORG), .MODEL_NUMBER_FIELD(6'h2D),
        .REVISION_FIELD(4'h9)) dut_u (.clk_sys(clk_sys), .rst(rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(4'h3),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .activeAbility(activeAbility), .activeRemoteFault(activeRemoteFault),
        .activeSelector(activeSelector), .activeNextPage(activeNextPage),
        .restartPulse(restartPulse));
    initial forever #20 clk_sys = ~clk_sys;
    // Compare and count
    task chk(input string n, input [31:0] s, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("wrong value %s exp %h seen %h", n, e, s);
            end
        end
    endtask
    // One bus cycle; held until waitrequest low, gap after to re-arm
    task acc(input w, input [4:0] a, input [15:0] d);
        begin
            avsAddress <= a;
            avsWriteData <= {16'h0000, d};
            avsWrite <= w;
            avsRead <= !w;
            @(posedge clk_sys);
            while (avsWaitRequest !== 1'b0) @(posedge clk_sys);
            rv = avsReadData[15:0];
            avsWrite <= 0;
            avsRead <= 0;
            @(posedge clk_sys);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            stop_test;
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        acc(0, 5'h08, 0);
        chk("idhi", rv, ORG[21:6]);
        acc(0, 5'h0C, 0);
        chk("idlo", rv, {ORG[5:0], 10'h2D9});
        acc(0, 5'h10, 0);
        chk("adv", rv, 16'h01E1);
        chk("abl", activeAbility, 4'hF);
        chk("sel", activeSelector, 5'h01);
        chk("np", activeNextPage, 1'h0);
        chk("flt0", activeRemoteFault, 1'h0);
        $display("reset test done");
        acc(1, 5'h08, 16'hFFFF);
        acc(0, 5'h08, 0);
        chk("idw", rv, ORG[21:6]);
        acc(1, 5'h10, 16'hDE1F);
        acc(0, 5'h10, 0);
        chk("adv", rv, 16'h0001);
        chk("held", activeAbility, 4'hF);
        acc(1, 5'h00, 16'h0200);
        @(posedge clk_sys);
        chk("abl", activeAbility, 4'h0);
        acc(1, 5'h10, 16'h2020);
        acc(0, 5'h10, 0);
        chk("adv", rv, 16'h2021);
        chk("fltheld", activeRemoteFault, 1'h0);
        acc(1, 5'h00, 16'h0200);
        @(posedge clk_sys);
        chk("abl", activeAbility, 4'h1);
        chk("flt", activeRemoteFault, 1'b1);
        acc(0, 5'h14, 0);
        chk("unmp", rv, 16'h0000);
        $display("write test done");
        stop_test;
    end
endmodule // test_pia_regs
